// ==== src/tscr_pkg.sv ====
package tscr_pkg;

    localparam int unsigned WORD_W = 6;

    // Register word indices; byte address is four times the index
    localparam logic [5:0] IDX_BOOT    = 6'h09;
    localparam logic [5:0] IDX_STATUS  = 6'h0a;
    localparam logic [5:0] IDX_CHANNEL_REQUEST    = 6'h0b;
    localparam logic [5:0] IDX_SPARE_A = 6'h0c;
    localparam logic [5:0] IDX_SPARE_B = 6'h0d;
    localparam logic [5:0] IDX_CTRL    = 6'h10;
    localparam logic [5:0] IDX_IRQ_STS = 6'h11;
    localparam logic [5:0] IDX_IRQ_EN  = 6'h12;
    localparam logic [5:0] IDX_IRQ_CLR = 6'h13;

    // Status word layout
    localparam int unsigned STS_DONE_BIT   = 14;
    localparam int unsigned STS_FAIL_BIT   = 13;
    localparam int unsigned STS_RAIL_BIT   = 12;
    localparam int unsigned STS_STEREO_BIT = 8;

    // Control word layout
    localparam int unsigned CTRL_TUNE_BIT  = 15;
    localparam int unsigned CTRL_WRAP_BIT  = 10;
    localparam int unsigned CTRL_SEEK_BIT  = 8;
    localparam int unsigned CTRL_BAND_LSB  = 6;
    localparam int unsigned CTRL_SPACE_LSB = 4;
    localparam int unsigned CTRL_PIN3_LSB  = 0;

    localparam logic [15:0] BOOT_RESET  = 16'h0000;
    localparam logic [15:0] SPARE_RESET = 16'h0000;
    localparam logic [15:0] CTRL_RESET  = 16'h0000;

    localparam logic [7:0]  RSSI_MAX     = 8'h4b;
    localparam logic [1:0]  BAND_EU      = 2'h0;
    localparam logic [1:0]  BAND_WIDE    = 2'h1;
    localparam logic [1:0]  BAND_JP      = 2'h2;
    localparam logic [1:0]  SPACE_200    = 2'h0;
    localparam logic [1:0]  SPACE_100    = 2'h1;
    localparam logic [1:0]  SPACE_50     = 2'h2;
    localparam logic [7:0]  STEP_200_KHZ = 8'hc8;
    localparam logic [7:0]  STEP_100_KHZ = 8'h64;
    localparam logic [7:0]  STEP_50_KHZ  = 8'h32;
    localparam logic [18:0] BASE_EU_KHZ  = 19'h155cc;
    localparam logic [18:0] BASE_JP_KHZ  = 19'h128e0;
    localparam logic [1:0]  PIN3_STEREO  = 2'h1;

    localparam int unsigned IRQ_DONE   = 0;
    localparam int unsigned IRQ_FAIL   = 1;
    localparam int unsigned IRQ_RAIL   = 2;
    localparam int unsigned IRQ_STEREO = 3;
    localparam int unsigned IRQ_W      = 4;

    typedef struct packed {
        logic       op_done;
        logic       seek_failed;
        logic       band_edge;
        logic       afc_railed;
        logic       stereo;
        logic       channel_request_update;
        logic [7:0] rssi;
        logic [9:0] channel;
    } tscr_tuner_type;

    typedef struct packed {
        logic       seek_request;
        logic       tune_request;
        logic       seek_wrap_select;
        logic [1:0] band_select;
        logic [1:0] channel_spacing;
        logic [1:0] pin3_function;
    } tscr_ctrl_type;

endpackage

// ==== src/tscr_readback.sv ====
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module tscr_readback #(
    parameter int unsigned ADR_W = 8
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [ADR_W-1:0]        wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    input  wire tscr_pkg::tscr_tuner_type tuner_i,
    output tscr_pkg::tscr_ctrl_type      ctrl_o,
    output logic                         softmute_o,
    output logic                         pin3_o,
    output logic                         pin3_oe_o,
    output logic      [18:0]             freq_khz_o,
    output logic                         irq_o
);

    ////////////////////////////////////////////////////////////////////////
    logic [5:0]                  word;
    logic                        hit;
    logic                        wr;
    logic                        ack_reg;
    logic [31:0]                 rdata_reg;
    logic [31:0]                 rdata_next;
    logic [15:0]                 boot_reg;
    logic [15:0]                 ctrl_reg;
    logic                        seek_prev_reg;
    logic                        tune_prev_reg;
    logic                        seek_fall;
    logic                        tune_fall;
    logic                        fail_evt;
    logic                        done_reg;
    logic                        fail_reg;
    logic                        rail_reg;
    logic                        stereo_reg;
    logic [7:0]                  rssi_reg;
    logic [9:0]                  channel_request_reg;
    logic                        pin3_reg;
    logic                        pin3_oe_reg;
    logic [18:0]                 freq_reg;
    logic [7:0]                  step_khz;
    logic [18:0]                 base_khz;
    logic [15:0]                 status_word;
    logic [tscr_pkg::IRQ_W-1:0]  irq_evt;
    logic [tscr_pkg::IRQ_W-1:0]  irq_sts_reg;
    logic [tscr_pkg::IRQ_W-1:0]  irq_en_reg;

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
        logic [15:0] r;
        r = old_v;
        if (sel[0])
        begin
            r[7:0] = new_v[7:0];
        end
        if (sel[1])
        begin
            r[15:8] = new_v[15:8];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Wishbone classic slave, one wait state, ack for every address

    assign word     = wb_adr_i[7:2];
    assign hit      = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr       = hit && wb_we_i;
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= hit;
        end
    end

    assign status_word = {1'b0, done_reg, fail_reg, rail_reg, 3'h0,
                          stereo_reg, rssi_reg};

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (word == tscr_pkg::IDX_BOOT)
        begin
            rdata_next[15:0] = boot_reg;
        end
        else if (word == tscr_pkg::IDX_STATUS)
        begin
            rdata_next[15:0] = status_word;
        end
        else if (word == tscr_pkg::IDX_CHANNEL_REQUEST)
        begin
            rdata_next[15:0] = {6'h00, channel_request_reg};
        end
        else if (word == tscr_pkg::IDX_SPARE_A || word == tscr_pkg::IDX_SPARE_B)
        begin
            rdata_next[15:0] = tscr_pkg::SPARE_RESET;
        end
        else if (word == tscr_pkg::IDX_CTRL)
        begin
            rdata_next[15:0] = ctrl_reg;
        end
        else if (word == tscr_pkg::IDX_IRQ_STS)
        begin
            rdata_next[tscr_pkg::IRQ_W-1:0] = irq_sts_reg;
        end
        else if (word == tscr_pkg::IDX_IRQ_EN)
        begin
            rdata_next[tscr_pkg::IRQ_W-1:0] = irq_en_reg;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_reg <= 32'h0000_0000;
        end
        else if (hit && !wb_we_i)
        begin
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Writable words; status, channel and spare words have no write path

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            boot_reg <= tscr_pkg::BOOT_RESET;
        end
        else if (wr && word == tscr_pkg::IDX_BOOT)
        begin
            // Stored as given; host is expected to write back what it read
            boot_reg <= merge16(boot_reg, wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_reg <= tscr_pkg::CTRL_RESET;
        end
        else if (wr && word == tscr_pkg::IDX_CTRL)
        begin
            ctrl_reg <= merge16(ctrl_reg, wb_dat_i, wb_sel_i);
        end
    end

    always_comb
    begin
        ctrl_o.seek_request     = ctrl_reg[tscr_pkg::CTRL_SEEK_BIT];
        ctrl_o.tune_request     = ctrl_reg[tscr_pkg::CTRL_TUNE_BIT];
        ctrl_o.seek_wrap_select = ctrl_reg[tscr_pkg::CTRL_WRAP_BIT];
        ctrl_o.band_select      = ctrl_reg[tscr_pkg::CTRL_BAND_LSB +: 2];
        ctrl_o.channel_spacing  = ctrl_reg[tscr_pkg::CTRL_SPACE_LSB +: 2];
        ctrl_o.pin3_function    = ctrl_reg[tscr_pkg::CTRL_PIN3_LSB +: 2];
    end

    ////////////////////////////////////////////////////////////////////////
    // Completion and seek failure flags

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            seek_prev_reg <= 1'b0;
            tune_prev_reg <= 1'b0;
        end
        else
        begin
            seek_prev_reg <= ctrl_o.seek_request;
            tune_prev_reg <= ctrl_o.tune_request;
        end
    end

    assign seek_fall = seek_prev_reg && !ctrl_o.seek_request;
    assign tune_fall = tune_prev_reg && !ctrl_o.tune_request;

    // Failure meaning depends on the wrap mode
    assign fail_evt = tuner_i.op_done && ctrl_o.seek_request &&
                      (ctrl_o.seek_wrap_select ? tuner_i.band_edge
                                               : tuner_i.seek_failed);

    // A completion in the clearing cycle wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            done_reg <= 1'b0;
        end
        else if (tuner_i.op_done)
        begin
            done_reg <= 1'b1;
        end
        else if (seek_fall || tune_fall)
        begin
            done_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fail_reg <= 1'b0;
        end
        else if (fail_evt)
        begin
            fail_reg <= 1'b1;
        end
        else if (seek_fall)
        begin
            fail_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reception state, sampled every cycle except the channel, taken on update or completion

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rail_reg   <= 1'b0;
            stereo_reg <= 1'b0;
            rssi_reg   <= 8'h00;
        end
        else
        begin
            rail_reg   <= tuner_i.afc_railed;
            stereo_reg <= tuner_i.stereo;
            // Unsigned dBuV code, clipped at the top of the range
            rssi_reg   <= (tuner_i.rssi > tscr_pkg::RSSI_MAX) ? tscr_pkg::RSSI_MAX
                                                             : tuner_i.rssi;
        end
    end

    assign softmute_o = rail_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            channel_request_reg <= 10'h000;
        end
        else if (tuner_i.channel_request_update || tuner_i.op_done)
        begin
            channel_request_reg <= tuner_i.channel;
        end
    end

    // Pin is released unless programmed as stereo indicator
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin3_reg    <= 1'b0;
            pin3_oe_reg <= 1'b0;
        end
        else
        begin
            pin3_oe_reg <= (ctrl_o.pin3_function == tscr_pkg::PIN3_STEREO);
            pin3_reg    <= (ctrl_o.pin3_function == tscr_pkg::PIN3_STEREO) &&
                           tuner_i.stereo;
        end
    end

    assign pin3_o    = pin3_reg;
    assign pin3_oe_o = pin3_oe_reg;

    ////////////////////////////////////////////////////////////////////////
    // Channel to frequency in kHz; reserved codes fall back to defaults

    always_comb
    begin
        if (ctrl_o.channel_spacing == tscr_pkg::SPACE_100)
        begin
            step_khz = tscr_pkg::STEP_100_KHZ;
        end
        else if (ctrl_o.channel_spacing == tscr_pkg::SPACE_50)
        begin
            step_khz = tscr_pkg::STEP_50_KHZ;
        end
        else
        begin
            step_khz = tscr_pkg::STEP_200_KHZ;
        end
        if (ctrl_o.band_select == tscr_pkg::BAND_WIDE ||
            ctrl_o.band_select == tscr_pkg::BAND_JP)
        begin
            base_khz = tscr_pkg::BASE_JP_KHZ;
        end
        else
        begin
            base_khz = tscr_pkg::BASE_EU_KHZ;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            freq_reg <= tscr_pkg::BASE_EU_KHZ;
        end
        else
        begin
            // Product widened first so large channel indices do not wrap
            freq_reg <= base_khz + {1'b0, 18'(step_khz) * 18'(channel_request_reg)};
        end
    end

    assign freq_khz_o = freq_reg;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt: sticky status, write-one clear, enable mask

    assign irq_evt[tscr_pkg::IRQ_DONE]   = tuner_i.op_done;
    assign irq_evt[tscr_pkg::IRQ_FAIL]   = fail_evt;
    assign irq_evt[tscr_pkg::IRQ_RAIL]   = tuner_i.afc_railed && !rail_reg;
    assign irq_evt[tscr_pkg::IRQ_STEREO] = tuner_i.stereo != stereo_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_en_reg <= '0;
        end
        else if (wr && word == tscr_pkg::IDX_IRQ_EN && wb_sel_i[0])
        begin
            irq_en_reg <= wb_dat_i[tscr_pkg::IRQ_W-1:0];
        end
    end

    for (genvar i = 0; i < tscr_pkg::IRQ_W; i++)
    begin : g_irq
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                irq_sts_reg[i] <= 1'b0;
            end
            else if (irq_evt[i])
            begin
                irq_sts_reg[i] <= 1'b1;
            end
            else if (wr && word == tscr_pkg::IDX_IRQ_CLR && wb_sel_i[0] && wb_dat_i[i])
            begin
                irq_sts_reg[i] <= 1'b0;
            end
        end
    end

    assign irq_o = |(irq_sts_reg & irq_en_reg);

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_DONE_SET: assert property (tuner_i.op_done |=> status_word[14] ##1 1'b1)
        else $error("done flag not set after completion");
    AST_DONE_HOLD: assert property (done_reg && !seek_fall && !tune_fall |=> done_reg)
        else $error("done flag dropped without request clear");
    AST_DONE_CLR: assert property ((seek_fall || tune_fall) && !tuner_i.op_done |=> !done_reg)
        else $error("done flag not cleared by request drop");
    AST_FAIL_NOWRAP: assert property (tuner_i.op_done && ctrl_o.seek_request &&
                                      !ctrl_o.seek_wrap_select && tuner_i.seek_failed
                                      |=> fail_reg)
        else $error("seek failure not flagged");
    AST_FAIL_WRAP: assert property (tuner_i.op_done && ctrl_o.seek_request &&
                                    ctrl_o.seek_wrap_select && tuner_i.band_edge
                                    |=> fail_reg)
        else $error("band limit not flagged");
    AST_FAIL_HOLD: assert property (fail_reg && !seek_fall |=> fail_reg)
        else $error("fail flag dropped while seek held");
    AST_RAIL_MUTE: assert property (tuner_i.afc_railed |=> softmute_o && status_word[12])
        else $error("railed state not muted or reported");
    AST_RAIL_TRACK: assert property (!tuner_i.afc_railed ##1 !tuner_i.afc_railed
                                     |=> !softmute_o)
        else $error("railed flag stuck");
    AST_PIN3: assert property (ctrl_o.pin3_function == 2'h1 && tuner_i.stereo
                               |=> pin3_oe_o && pin3_o && $past(tuner_i.stereo))
        else $error("stereo not mirrored on pin");
    AST_RSSI_SAT: assert property (tuner_i.rssi > 8'h4b |=> rssi_reg == 8'h4b)
        else $error("strength not saturated");
    AST_CHANNEL_REQUEST: assert property (tuner_i.channel_request_update |=> channel_request_reg == $past(tuner_i.channel))
        else $error("channel not captured");
    AST_SPARE: assert property (hit && !wb_we_i && word == 6'h0c
                                |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
        else $error("spare word not zero");
    AST_RO_CHANNEL_REQUEST: assert property (wr && word == 6'h0b && !tuner_i.channel_request_update &&
                                  !tuner_i.op_done |=> $stable(channel_request_reg))
        else $error("write changed channel readback");

    COV_SEEK_FAIL: cover property (fail_evt ##[1:50] seek_fall);
    COV_TUNE_DONE: cover property (tuner_i.op_done ##[1:50] tune_fall);
    COV_IRQ: cover property (irq_o ##[1:20] !irq_o);
    COV_READ_STATUS: cover property (hit && !wb_we_i && word == 6'h0a);

endmodule

`default_nettype wire

// ==== bench/tscr_tuner_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module tscr_tuner_model (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire tscr_pkg::tscr_ctrl_type  ctrl_i,
    input  wire tscr_pkg::tscr_tuner_type level_i,
    input  wire logic [7:0]               delay_i,
    input  wire logic                     fail_i,
    input  wire logic                     edge_i,
    output tscr_pkg::tscr_tuner_type      tuner_o
);
    logic       busy_reg;
    logic       req_reg;
    logic [7:0] cnt_reg;
    logic       req;

    assign req = ctrl_i.seek_request | ctrl_i.tune_request;

    ////////////////////////////////////////////////////////////////////////////
    // Rising request starts an operation that ends after delay_i cycles
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            busy_reg <= 1'b0;
            req_reg  <= 1'b0;
            cnt_reg  <= 8'h00;
            tuner_o  <= '0;
        end
        else
        begin
            req_reg                <= req;
            tuner_o                <= level_i;
            tuner_o.op_done        <= 1'b0;
            tuner_o.seek_failed    <= 1'b0;
            tuner_o.band_edge      <= 1'b0;
            tuner_o.channel_request_update    <= busy_reg & ctrl_i.seek_request;
            if (req && !req_reg)
            begin
                busy_reg <= 1'b1;
                cnt_reg  <= delay_i;
            end
            else if (busy_reg && cnt_reg <= 8'h01)
            begin
                busy_reg            <= 1'b0;
                tuner_o.op_done     <= 1'b1;
                tuner_o.seek_failed <= fail_i;
                tuner_o.band_edge   <= edge_i;
            end
            else if (busy_reg)
            begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end
endmodule

`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic                     clk_i = 1'b0;
    logic                     rst_i = 1'b1;
    logic                     cyc = 1'b0;
    logic                     stb = 1'b0;
    logic                     we = 1'b0;
    logic [7:0]               adr = 8'h00;
    logic [3:0]               sel = 4'h3;
    logic [31:0]              wdat = 32'h0;
    logic [31:0]              rdat;
    logic                     ack;
    tscr_pkg::tscr_ctrl_type  ctrl;
    tscr_pkg::tscr_tuner_type tuner;
    tscr_pkg::tscr_tuner_type level = '0;
    logic [7:0]               delay = 8'h01;
    logic                     fail = 1'b0;
    logic                     edg = 1'b0;
    logic                     mute;
    logic                     pin3;
    logic                     pin3_oe;
    logic [18:0]              freq;
    logic                     irq;
    int                       errors = 0;
    int                       num_checks = 0;

    always #12.5 clk_i = ~clk_i;

    tscr_readback tscr_readback_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .tuner_i(tuner), .ctrl_o(ctrl),
        .softmute_o(mute), .pin3_o(pin3), .pin3_oe_o(pin3_oe), .freq_khz_o(freq),
        .irq_o(irq));

    tscr_tuner_model tscr_tuner_model_inst (.clk_i(clk_i), .rst_i(rst_i), .ctrl_i(ctrl),
        .level_i(level), .delay_i(delay), .fail_i(fail), .edge_i(edg), .tuner_o(tuner));

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Master holds the request until ack is sampled, then idles one cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic [31:0] q);
        int n = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {16'h0000, d};
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 40)
        begin
            @(posedge clk_i);
            n++;
        end
        if (ack !== 1'b1)
        begin
            errors++;
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 16'h0000, q);
        chk(q, exp);
    endtask

    // Polls the status word until a bit reaches the wanted level
    task automatic wait_bit(input int b, input logic v);
        logic [31:0] q;
        int n = 0;
        wb(1'b0, 8'h28, 16'h0000, q);
        while (q[b] !== v && n < 40)
        begin
            wb(1'b0, 8'h28, 16'h0000, q);
            n++;
        end
        if (q[b] !== v)
        begin
            errors++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] q;
        chk({13'h0, freq}, 32'h000155cc);
        wb(1'b0, 8'h24, 16'h0000, q);
        chk(q, 32'h0);
        wr(8'h24, q[15:0]);
        rd_chk(8'h28, 32'h0);
        wr(8'h30, 16'h1234);
        rd_chk(8'h30, 32'h0);
        rd_chk(8'h34, 32'h0);
        rd_chk(8'h3c, 32'h0);
        $display("reset test done");
    endtask

    task automatic t_tune();
        level.rssi    <= 8'h30;
        level.stereo  <= 1'b1;
        level.channel <= 10'h00a;
        wr(8'h40, 16'h8000);
        wait_bit(14, 1'b1);
        rd_chk(8'h28, 32'h4130);
        rd_chk(8'h2c, 32'h000a);
        chk({13'h0, freq}, 32'h00015d9c);
        wr(8'h28, 16'h0000);
        rd_chk(8'h28, 32'h4130);
        wr(8'h2c, 16'h0000);
        rd_chk(8'h2c, 32'h000a);
        wr(8'h40, 16'h0000);
        rd_chk(8'h28, 32'h0130);
        $display("tune test done");
    endtask

    task automatic t_band();
        int base;
        int step;
        for (int b = 0; b < 3; b++)
        begin
            for (int s = 0; s < 3; s++)
            begin
                wr(8'h40, {8'h00, b[1:0], s[1:0], 4'h0});
                @(posedge clk_i);
                base = (b == 0) ? 87500 : 76000;
                step = (s == 0) ? 200 : (s == 1) ? 100 : 50;
                chk({13'h0, freq}, base + step * 10);
                chk(32'({ctrl.band_select, ctrl.channel_spacing}), b * 4 + s);
            end
        end
        wr(8'h40, 16'h0000);
        $display("band test done");
    endtask

    task automatic t_seek();
        logic [15:0] cw [3] = '{16'h0100, 16'h0500, 16'h0100};
        logic [31:0] ex [3] = '{32'h6130, 32'h6130, 32'h4130};
        for (int i = 0; i < 3; i++)
        begin
            fail          <= (i == 0);
            edg           <= (i != 0);
            delay         <= 8'd20;
            level.channel <= 10'h0a0 + 10'(i);
            wr(8'h40, cw[i]);
            wait_bit(14, 1'b1);
            rd_chk(8'h28, ex[i]);
            rd_chk(8'h2c, 32'h0a0 + i);
            wr(8'h40, cw[i] & 16'h0400);
            rd_chk(8'h28, 32'h0130);
        end
        fail <= 1'b0;
        edg  <= 1'b0;
        $display("seek test done");
    endtask

    task automatic t_rail();
        logic [7:0] v [4] = '{8'h00, 8'h4b, 8'h4c, 8'hff};
        level.afc_railed <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            level.rssi <= v[i];
            // One edge into the tuner model, one more into the status word
            repeat (2) @(posedge clk_i);
            rd_chk(8'h28, {20'h00011, (v[i] > 8'h4b) ? 8'h4b : v[i]});
            chk(mute, 1'b1);
        end
        level.afc_railed <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd_chk(8'h28, 32'h01ff & {24'h1, 8'h4b});
        chk(mute, 1'b0);
        $display("rail test done");
    endtask

    task automatic t_pin3();
        wr(8'h40, 16'h0001);
        chk(pin3_oe, 1'b1);
        chk(pin3, 1'b1);
        level.stereo <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(pin3, 1'b0);
        wr(8'h40, 16'h0000);
        chk(pin3_oe, 1'b0);
        level.stereo <= 1'b1;
        $display("pin3 test done");
    endtask

    task automatic t_irq();
        delay <= 8'h01;
        wr(8'h48, 16'h0000);
        wr(8'h4c, 16'h000f);
        wr(8'h40, 16'h8000);
        wait_bit(14, 1'b1);
        chk(irq, 1'b0);
        rd_chk(8'h44, 32'h1);
        wr(8'h48, 16'h0001);
        chk(irq, 1'b1);
        wr(8'h4c, 16'h0001);
        chk(irq, 1'b0);
        rd_chk(8'h44, 32'h0);
        wr(8'h40, 16'h0000);
        $display("irq test done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_tune();
        t_band();
        t_seek();
        t_rail();
        t_pin3();
        t_irq();
        end_sim();
    end

    // Whole run needs a few hundred cycles
    initial
    begin
        repeat (30000) @(posedge clk_i);
        errors++;
        end_sim();
    end
endmodule

`default_nettype wire
